// ---- hw/fsbp_status_protect.sv ----
`timescale 1ns/1ps
// Contract
// RL1 - Read-status returns register; write-status updates writable bits.
// RL2 - Lock bit set with write-protect low ignores status writes.
// RL3 - Hardware protection ends only when write-protect pin goes high.
// RL4 - Bit 7 nonvolatile lock; default 1 blocks writes with pin low.
// RL5 - Bit 5 selects top (0) or bottom (1, default) anchoring.
// RL6 - Block-protect bits at 6 and 4:2 refuse program/erase in range.
// RL7 - Write-enable latch bit 1 clears at power-up; needed before writes.
// RL8 - Bit 0 reads 1 while internal write, program or erase runs.
// RL9 - Bulk erase runs only when all block-protect bits are zero.
// RL10 - Write-in-progress is inverse of flag status ready bit.
// RL11 - Value n protects 2^(n-1) sectors; zero none; 11+ all.
// RL12 - 26-bit address decodes to 64KB, 32KB and 4KB units.
// RL13 - Protected program or erase sets protection error flag instead.
// RL14 - Write-status needs latch set; latch clears when cycle completes.
module fsbp_status_protect
    import fsbp_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic writeProtectN,
    input wire logic rdStatReq,
    input wire logic wrStatReq,
    input wire logic [fsbp_pkg::STAT_W-1:0] wrStatData,
    input wire logic wrEnableReq,
    input wire logic wrDisableReq,
    input wire logic opReq,
    input wire fsbp_pkg::fsbp_op_t opCode,
    input wire logic [fsbp_pkg::ADDR_W-1:0] opAddr,
    input wire logic opDone,
    input wire logic clrFlagReq,
    output logic [fsbp_pkg::STAT_W-1:0] rdStatData,
    output logic rdStatValid,
    output logic opStart,
    output logic opRefused,
    output logic [fsbp_pkg::SECT_W-1:0] opSector,
    output logic [10:0] opSub32,
    output logic [13:0] opSub4,
    output logic flagReady,
    output logic flagProtErr,
    output logic hwProtected
);
    import fsbp_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic [2:0] wpSync_r;
    logic wpLevel_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wpSync_r <= 3'h7;
            wpLevel_r <= 1'b1;
        end else begin
            wpSync_r <= {wpSync_r[1:0], writeProtectN};
            // A change counts once the second and third stages agree.
            if (wpSync_r[1] == wpSync_r[2]) begin
                wpLevel_r <= wpSync_r[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status state
    // ------------------------------------------------------------------
    logic swl_r;
    logic tb_r;
    logic [3:0] bp_r;
    logic wel_r;
    logic [STAT_W-1:0] pendData_r;
    logic pendStat_r;
    fsbp_state_t state_r;
    logic [$clog2(WRITE_CYCLES+1)-1:0] cnt_r;

    logic locked;
    logic wrStatOk;
    logic statFinish;
    logic protHit;
    logic opAllowed;
    logic busy;
    logic opStartNxt;
    logic opRefuseNxt;

    // The lock persists until the filtered pin reads high again.
    assign locked = swl_r && !wpLevel_r; // [RL2] [RL3] [RL4]
    assign busy = (state_r != FSBP_IDLE);
    assign wrStatOk = wrStatReq && wel_r && !locked && !busy; // [RL2] [RL14]
    assign statFinish = (state_r == FSBP_BUSY) && pendStat_r
        && (cnt_r == '0);

    fsbp_range_check u_range (
        .bp(bp_r),
        .bottom(tb_r),
        .sector(opAddr[SECT_LSB +: SECT_W]),
        .hit(protHit)
    );

    always_comb begin
        case (opCode)
            FSBP_OP_BULK: opAllowed = (bp_r == 4'h0); // [RL9]
            FSBP_OP_NVCFG: opAllowed = 1'b1;
            FSBP_OP_PROG,
            FSBP_OP_SE64,
            FSBP_OP_SE32,
            FSBP_OP_SE4: opAllowed = !protHit; // [RL6]
            default: opAllowed = 1'b0;
        endcase
    end

    // Status nonvolatile bits; the power-up values stand in for the
    // stored copy since the array itself is outside this block.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            swl_r <= NV_SWL_RST;
            tb_r <= NV_TB_RST;
            bp_r <= NV_BP_RST;
        end else if (statFinish) begin
            swl_r <= pendData_r[BIT_SWL]; // [RL1] [RL4]
            tb_r <= pendData_r[BIT_TB]; // [RL5]
            bp_r <= {pendData_r[BIT_BP3], pendData_r[BIT_BP2],
                pendData_r[BIT_BP1], pendData_r[BIT_BP0]}; // [RL6]
        end
    end

    // Write enable latch.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wel_r <= 1'b0; // [RL7]
        end else if ((state_r == FSBP_DONE) || wrDisableReq) begin
            wel_r <= 1'b0; // [RL14]
        end else if (wrEnableReq && !busy) begin
            wel_r <= 1'b1; // [RL7]
        end else if (opStartNxt) begin
            // Array operations consume the latch at start.
            wel_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Internal cycle sequencer
    // ------------------------------------------------------------------
    assign opStartNxt = opReq && wel_r && !busy && !wrStatReq
        && opAllowed; // [RL7]
    assign opRefuseNxt = opReq && wel_r && !busy && !wrStatReq
        && !opAllowed; // [RL13]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= FSBP_IDLE;
            cnt_r <= '0;
            pendStat_r <= 1'b0;
            pendData_r <= '0;
        end else begin
            case (state_r)
                FSBP_IDLE: begin
                    if (wrStatOk) begin
                        state_r <= FSBP_BUSY;
                        pendStat_r <= 1'b1;
                        pendData_r <= wrStatData;
                        cnt_r <= ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES - 1);
                    end else if (opStartNxt) begin
                        state_r <= FSBP_BUSY;
                        pendStat_r <= 1'b0;
                    end
                end
                FSBP_BUSY: begin
                    if (pendStat_r) begin
                        if (cnt_r == '0) begin
                            state_r <= FSBP_DONE;
                        end else begin
                            cnt_r <= cnt_r - 1'b1;
                        end
                    end else if (opDone) begin
                        state_r <= FSBP_DONE;
                    end
                end
                FSBP_DONE: begin
                    state_r <= FSBP_IDLE;
                    pendStat_r <= 1'b0;
                end
                default: state_r <= FSBP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdStatData <= '0;
            rdStatValid <= 1'b0;
        end else begin
            rdStatValid <= rdStatReq;
            if (rdStatReq) begin
                rdStatData <= {swl_r, bp_r[3], tb_r, bp_r[2:0], wel_r,
                    busy}; // [RL1] [RL8]
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flagReady <= 1'b1;
        end else begin
            flagReady <= !(busy || wrStatOk || opStartNxt) ||
                (state_r == FSBP_DONE); // [RL10]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flagProtErr <= 1'b0;
        end else if (opRefuseNxt) begin
            flagProtErr <= 1'b1; // [RL13]
        end else if (clrFlagReq) begin
            flagProtErr <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opStart <= 1'b0;
            opRefused <= 1'b0;
            opSector <= '0;
            opSub32 <= '0;
            opSub4 <= '0;
            hwProtected <= 1'b0;
        end else begin
            opStart <= opStartNxt;
            opRefused <= opRefuseNxt;
            hwProtected <= locked;
            if (opReq) begin
                opSector <= opAddr[SECT_LSB +: SECT_W]; // [RL12]
                opSub32 <= opAddr[SUB32_LSB +: SUB32_W]; // [RL12]
                opSub4 <= opAddr[SUB4_LSB +: SUB4_W]; // [RL12]
            end
        end
    end
endmodule // fsbp_status_protect

// ---- hw/fsbp_pkg.sv ----
package fsbp_pkg;

    // ------------------------------------------------------------------
    // Status register layout
    // ------------------------------------------------------------------
    localparam int STAT_W = 8;
    localparam int BIT_SWL = 7;   // status write lock
    localparam int BIT_BP3 = 6;
    localparam int BIT_TB = 5;    // top/bottom selector
    localparam int BIT_BP2 = 4;
    localparam int BIT_BP1 = 3;
    localparam int BIT_BP0 = 2;
    localparam int BIT_WEL = 1;   // write enable latch
    localparam int BIT_WIP = 0;   // write in progress
    localparam int FLAG_READY_BIT = 7;
    localparam int FLAG_PROT_BIT = 1;

    // Nonvolatile defaults: lock set, bottom anchored, nothing protected.
    localparam logic NV_SWL_RST = 1'b1;
    localparam logic NV_TB_RST = 1'b1;
    localparam logic [3:0] NV_BP_RST = 4'h0;

    // ------------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 26;
    localparam int SECT_W = 10;           // 1024 sectors of 64KB
    localparam int SECT_LSB = 16;
    localparam int SUB32_LSB = 15;
    localparam int SUB4_LSB = 12;
    localparam int SUB32_W = 11;          // 2048 subsectors of 32KB
    localparam int SUB4_W = 14;           // 16384 subsectors of 4KB
    localparam logic [3:0] BP_ALL = 4'hB; // 11 and above protect all

    // Internal nonvolatile write time, in clock cycles.
    localparam int WRITE_CYCLES_DEF = 16;

    // ------------------------------------------------------------------
    // Operation codes seen from the command decoder
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FSBP_OP_NONE = 3'h0,
        FSBP_OP_PROG = 3'h1,
        FSBP_OP_SE64 = 3'h2,
        FSBP_OP_SE32 = 3'h3,
        FSBP_OP_SE4 = 3'h4,
        FSBP_OP_BULK = 3'h5,
        FSBP_OP_NVCFG = 3'h6
    } fsbp_op_t;

    typedef enum logic [1:0] {
        FSBP_IDLE = 2'b00,
        FSBP_BUSY = 2'b01,
        FSBP_DONE = 2'b11
    } fsbp_state_t;

endpackage

// ---- hw/fsbp_range_check.sv ----
`timescale 1ns/1ps
// Combinational protected-range test for one 64KB sector index.
module fsbp_range_check
    import fsbp_pkg::*;
#(
    parameter int SW = SECT_W
) (
    input wire logic [3:0] bp,
    input wire logic bottom,
    input wire logic [SW-1:0] sector,
    output logic hit
);
    logic [SW:0] count;
    logic [SW:0] secExt;

    always_comb begin
        // Value n protects 2^(n-1) sectors; 11 and up protect all.
        if (bp == 4'h0) begin
            count = '0;
        end else if (bp >= BP_ALL) begin
            count = (SW+1)'(1) << SW;
        end else begin
            count = (SW+1)'(1) << (bp - 4'h1);
        end
        secExt = {1'b0, sector};
        if (bottom) begin
            hit = secExt < count; // [RL11]
        end else begin
            hit = secExt >= ((SW+1)'(1) << SW) - count; // [RL11]
        end
    end
endmodule // fsbp_range_check

// ---- testbench/fsbp_status_protect_sva.sv ----
`timescale 1ns/1ps
module fsbp_status_protect_sva
    import fsbp_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic writeProtectN,
    input wire logic rdStatReq,
    input wire logic wrStatReq,
    input wire logic [fsbp_pkg::STAT_W-1:0] wrStatData,
    input wire logic wrEnableReq,
    input wire logic wrDisableReq,
    input wire logic opReq,
    input wire fsbp_pkg::fsbp_op_t opCode,
    input wire logic [fsbp_pkg::ADDR_W-1:0] opAddr,
    input wire logic opDone,
    input wire logic clrFlagReq,
    input wire logic [fsbp_pkg::STAT_W-1:0] rdStatData,
    input wire logic rdStatValid,
    input wire logic opStart,
    input wire logic opRefused,
    input wire logic [fsbp_pkg::SECT_W-1:0] opSector,
    input wire logic [10:0] opSub32,
    input wire logic [13:0] opSub4,
    input wire logic flagReady,
    input wire logic flagProtErr,
    input wire logic hwProtected
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    rd_answer_a: assert property (rdStatReq |=> rdStatValid)
        else $error("read not answered");
    start_cause_a: assert property (opStart |-> $past(opReq))
        else $error("start without request");
    refuse_cause_a: assert property (opRefused |->
        $past(opReq) && $past(opCode) != FSBP_OP_NVCFG)
        else $error("bad refusal");
    op_excl_a: assert property (!(opStart && opRefused))
        else $error("start and refuse together");
    hw_release_a: assert property (writeProtectN [*6] |-> !hwProtected)
        else $error("protection kept with pin high");
    busy_start_a: assert property (opStart |-> ##[0:2] !flagReady)
        else $error("no busy after start");
    addr_decode_a: assert property (opReq |=>
        opSector == $past(opAddr[25:16]) && opSub32 == $past(opAddr[25:15])
        && opSub4 == $past(opAddr[25:12])) else $error("bad decode");
    err_set_a: assert property (opRefused |-> ##[0:1] flagProtErr)
        else $error("error flag not set");
    err_hold_a: assert property (flagProtErr && !clrFlagReq |=>
        flagProtErr) else $error("error flag lost");
    wip_inverse_a: assert property (rdStatValid |->
        rdStatData[0] == !$past(flagReady))
        else $error("busy bit disagrees with ready flag");
    cover property (opRefused);
    cover property (opStart ##[1:20] opDone);
    cover property (rdStatValid && rdStatData[0]);
endmodule // fsbp_status_protect_sva

bind fsbp_status_protect fsbp_status_protect_sva #(
    .WRITE_CYCLES(WRITE_CYCLES)
) chk_u (.*);

// ---- testbench/fsbp_engine_model.sv ----
`timescale 1ns/1ps
// Array engine stand-in: raises opDone lat+3 cycles after each opStart.
module fsbp_engine_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic opStart,
    input wire logic [3:0] lat,
    output logic opDone
);
    logic [4:0] cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 5'h00;
            opDone <= 1'b0;
        end else begin
            cnt_r <= opStart ? {1'b0, lat} + 5'h02 :
                cnt_r - {4'h0, cnt_r != 5'h00};
            opDone <= (cnt_r == 5'h01);
        end
    end
endmodule // fsbp_engine_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
    import fsbp_pkg::*;
    logic clk = 0, rst = 1, writeProtectN = 0, rdStatReq = 0, wrStatReq = 0;
    logic wrEnableReq = 0, wrDisableReq = 0, opReq = 0, clrFlagReq = 0;
    logic [7:0] wrStatData = 8'h00, rdStatData;
    fsbp_op_t opCode = FSBP_OP_NONE;
    logic [25:0] opAddr = 26'h0;
    logic [3:0] lat = 4'h0;
    logic opDone, rdStatValid, opStart, opRefused, flagReady;
    logic flagProtErr, hwProtected;
    logic [9:0] opSector, s;
    logic [10:0] opSub32;
    logic [13:0] opSub4;
    logic [15:0] rnd = 16'h0058;
    logic [7:0] expQ[$], opQ[$];
    int mismatches = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    fsbp_status_protect #(.WRITE_CYCLES(4)) dut_u (.*);
    fsbp_engine_model eng_u (.clk(clk), .rst(rst), .opStart(opStart),
        .lat(lat), .opDone(opDone));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic int cn(input int n);
        return (n == 0) ? 0 : (n >= 11) ? 1024 : (1 << (n - 1));
    endfunction
    function automatic logic pr(input int t, input int n, input int v);
        return t ? (v < cn(n)) : (v >= 1024 - cn(n));
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clk);
        #2;
    endtask
    // A bounded wait: a stuck busy flag ends the run as a failure.
    task automatic waitReady();
        int i;
        tick();
        tick();
        for (i = 0; i < 200 && flagReady !== 1'b1; i++) tick();
        if (i == 200) begin
            mismatches++;
            results();
        end
    endtask
    task automatic rd(input logic [7:0] e);
        expQ.push_back(e);
        rdStatReq = 1;
        tick();
        rdStatReq = 0;
        tick();
    endtask
    task automatic wel();
        wrEnableReq = 1;
        tick();
        wrEnableReq = 0;
    endtask
    task automatic ws(input logic [7:0] d);
        wel();
        wrStatReq = 1;
        wrStatData = d;
        tick();
        wrStatReq = 0;
    endtask
    task automatic op(input fsbp_op_t c, input logic [25:0] a, input logic e);
        wel();
        opQ.push_back({7'h0, e});
        opReq = 1;
        opCode = c;
        opAddr = a;
        lat = rnd[3:0];
        tick();
        chk(16'(opSector), 16'(a[25:16]));
        chk(16'(opSub32), 16'(a[25:15]));
        chk(16'(opSub4), 16'(a[25:12]));
        opReq = 0;
        waitReady();
        if (!e) begin
            chk({7'h0, flagProtErr}, 8'h01);
            clrFlagReq = 1;
            tick();
            clrFlagReq = 0;
            tick();
            chk({7'h0, flagProtErr}, 8'h00);
        end
    endtask
    always @(posedge clk) begin
        #1;
        if (rdStatValid === 1'b1) chk(rdStatData, expQ.pop_front());
        if ((opStart | opRefused) === 1'b1) chk({7'h0, opStart},
            opQ.pop_front());
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        #2 rst = 0;
        repeat (4) tick();
        rd(8'hA0);
        wel();
        rd(8'hA2);
        wrDisableReq = 1;
        tick();
        wrDisableReq = 0;
        rd(8'hA0);
        ws(8'h00);
        waitReady();
        rd(8'hA2);
        chk({7'h0, hwProtected}, 8'h01);
        $display("test lock done");
        writeProtectN = 1;
        repeat (6) tick();
        chk({7'h0, hwProtected}, 8'h00);
        ws(8'h00);
        tick();
        rd(8'hA3);
        chk({7'h0, flagReady}, 8'h00);
        waitReady();
        rd(8'h00);
        $display("test write done");
        for (int t = 0; t < 2; t++) begin
            for (int n = 0; n < 16; n++) begin
                ws({1'b0, n[3], t[0], n[2:0], 2'b00});
                waitReady();
                for (int k = 0; k < 3; k++) begin
                    s = (k == 2) ? rnd[9:0] : 10'(t ? cn(n) - 1 + k :
                        1024 - cn(n) - k);
                    rnd = nx(rnd);
                    op(fsbp_op_t'(3'((k + n) % 4 + 1)), {s, rnd},
                        !pr(t, n, int'(s)));
                end
                op(FSBP_OP_BULK, {s, rnd}, n == 0);
            end
        end
        op(FSBP_OP_NVCFG, 26'h0, 1'b1);
        $display("test ranges done");
        results();
    end
endmodule // tb
